// ### hdl/sbs_sequencer.sv
// Behaviour
// RULE1: press from idle starts auto mode at once
// RULE2: hold over five seconds enters test run
// RULE3: one beep at fifth second of hold
// RULE4: new long hold within 20s arms toggle
// RULE5: two beeps at fifth second of hold
// RULE6: each press within 20s inverts feedback sound
// RULE7: long beep means off, short means on
// RULE8: expired window returns idle, keeps setting
module sbs_sequencer #(
	parameter longint unsigned HOLD_CYC  = sbs_pkg::HOLD_CYC,
	parameter longint unsigned WIN_CYC   = sbs_pkg::WIN_CYC,
	parameter longint unsigned SHORT_CYC = sbs_pkg::SHORT_CYC,
	parameter longint unsigned LONG_CYC  = sbs_pkg::LONG_CYC,
	parameter longint unsigned GAP_CYC   = sbs_pkg::GAP_CYC
) (
	// clock and reset
	input  wire logic CLK,
	input  wire logic RST,
	// service button pin, high while pressed
	input  wire logic BTN,
	// operating commands
	output logic      AUTO_START,
	output logic      TEST_RUN,
	// feedback sound setting
	output logic      FB_SOUND,
	// buzzer
	output logic      BUZZER
);
	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,  // waiting for a press
		S_HOLD1    = 3'b001,  // first press, timing the hold
		S_TEST     = 3'b010,  // test run, button still held
		S_WAIT2    = 3'b011,  // released, waiting for second hold
		S_HOLD2    = 3'b100,  // timing the second hold
		S_ARMED    = 3'b101,  // toggle stage reached, button held
		S_TOGGLE   = 3'b110   // toggle stage, button released
	} sbs_state_t;

	sbs_state_t  state;       // current state
	logic [2:0]  btn_sync;    // three-stage input synchroniser
	logic        btn;         // filtered button level
	logic        press;       // one-cycle press event
	logic [34:0] tmr;         // hold and window timer
	logic        hold_done;   // hold reached the fifth second
	logic        win_out;     // twenty-second window elapsed
	sbs_beep_if  bp ();       // beep request channel

	// synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			btn_sync <= 3'h0;
		end else begin
			btn_sync <= {btn_sync[1:0], BTN};
		end
	end

	// accept a change once the last two stages agree
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			btn <= 1'b0;
		end else if (btn_sync[1] == btn_sync[2]) begin
			btn <= btn_sync[2];
		end
	end

	// edge of the filtered level
	assign press     = btn_sync[1] & btn_sync[2] & ~btn;
	assign hold_done = (tmr >= 35'(HOLD_CYC - 1));
	assign win_out   = (tmr >= 35'(WIN_CYC - 1));

	// timer restarts on every press and every state change except the returns to S_IDLE
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tmr <= 35'h0_0000_0000;
		end else if (press || (state == S_HOLD1 && hold_done) || (state == S_HOLD2 && hold_done)
				|| (state == S_HOLD2 && !btn)  // [RULE8] fresh window after a short second hold
				|| (state == S_TEST && !btn) || (state == S_ARMED && !btn)) begin
			tmr <= 35'h0_0000_0000;
		end else if (!win_out) begin
			tmr <= tmr + 35'h0_0000_0001;
		end
	end

	// main sequence
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (press) begin
						state <= S_HOLD1;  // [RULE1]
					end
				end
				S_HOLD1: begin
					if (!btn) begin
						state <= S_IDLE;   // short press, auto mode only
					end else if (hold_done) begin
						state <= S_TEST;   // [RULE2]
					end
				end
				S_TEST: begin
					if (!btn) begin
						state <= S_WAIT2;
					end
				end
				S_WAIT2: begin
					if (press) begin
						state <= S_HOLD2;  // [RULE4]
					end else if (win_out) begin
						state <= S_IDLE;   // [RULE8]
					end
				end
				S_HOLD2: begin
					if (!btn) begin
						state <= S_WAIT2;  // too short, window restarts
					end else if (hold_done) begin
						state <= S_ARMED;  // [RULE4]
					end
				end
				S_ARMED: begin
					if (!btn) begin
						state <= S_TOGGLE;
					end
				end
				S_TOGGLE: begin
					if (win_out && !press) begin
						state <= S_IDLE;   // [RULE8]
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// operating command pulses
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			AUTO_START <= 1'b0;
			TEST_RUN   <= 1'b0;
		end else begin
			AUTO_START <= (state == S_IDLE) && press;               // [RULE1]
			TEST_RUN   <= (state == S_HOLD1) && btn && hold_done;  // [RULE2]
		end
	end

	// feedback setting flips on each press in the toggle stage
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			FB_SOUND <= sbs_pkg::FB_RESET;
		end else if (state == S_TOGGLE && press) begin
			FB_SOUND <= ~FB_SOUND;  // [RULE6]
		end
	end

	// beep requests
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bp.req  <= 1'b0;
			bp.kind <= sbs_pkg::SBS_BP_NONE;
		end else if (state == S_HOLD1 && btn && hold_done) begin
			bp.req  <= 1'b1;
			bp.kind <= sbs_pkg::SBS_BP_ONE;   // [RULE3]
		end else if (state == S_HOLD2 && btn && hold_done) begin
			bp.req  <= 1'b1;
			bp.kind <= sbs_pkg::SBS_BP_TWO;   // [RULE5]
		end else if (state == S_TOGGLE && press) begin
			bp.req  <= 1'b1;
			// new value is the inverse of the current one
			bp.kind <= FB_SOUND ? sbs_pkg::SBS_BP_LONG : sbs_pkg::SBS_BP_ONE;  // [RULE7]
		end else begin
			bp.req  <= 1'b0;
		end
	end

	// tone generator
	sbs_beeper #(
		.SHORT_CYC (SHORT_CYC),
		.LONG_CYC  (LONG_CYC),
		.GAP_CYC   (GAP_CYC)
	) u_beep (
		.clk (CLK),
		.rst (RST),
		.bp  (bp.gen)
	);

	// buzzer straight from a flip-flop
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			BUZZER <= 1'b0;
		end else begin
			BUZZER <= bp.tone;
		end
	end

	// assertions
	sequence s_hold_done1;
		state == S_HOLD1 && btn && hold_done;
	endsequence
	sequence s_toggle_press;
		state == S_TOGGLE && press;
	endsequence

	property p_auto_at_press;
		@(posedge CLK) disable iff (RST) (state == S_IDLE && press) |=> AUTO_START && state == S_HOLD1;
	endproperty
	a_auto_at_press: assert property (p_auto_at_press) else $error("auto start missed"); // [RULE1]

	property p_test_entry;
		@(posedge CLK) disable iff (RST) s_hold_done1 |=> TEST_RUN && state == S_TEST;
	endproperty
	a_test_entry: assert property (p_test_entry) else $error("test run not entered"); // [RULE2]

	property p_one_beep;
		@(posedge CLK) disable iff (RST) s_hold_done1 |=> bp.req && bp.kind == sbs_pkg::SBS_BP_ONE ##2 BUZZER;
	endproperty
	a_one_beep: assert property (p_one_beep) else $error("test run beep missing"); // [RULE3]

	property p_arm;
		@(posedge CLK) disable iff (RST) (state == S_HOLD2 && btn && hold_done) |=> state == S_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("toggle stage not armed"); // [RULE4]

	property p_two_beeps;
		@(posedge CLK) disable iff (RST)
			(state == S_HOLD2 && btn && hold_done) |=> bp.req && bp.kind == sbs_pkg::SBS_BP_TWO;
	endproperty
	a_two_beeps: assert property (p_two_beeps) else $error("double beep missing"); // [RULE5]

	property p_toggle;
		@(posedge CLK) disable iff (RST) s_toggle_press |=> FB_SOUND != $past(FB_SOUND);
	endproperty
	a_toggle: assert property (p_toggle) else $error("feedback setting not inverted"); // [RULE6]

	property p_report;
		@(posedge CLK) disable iff (RST)
			s_toggle_press |=> bp.req && (bp.kind == (FB_SOUND ? sbs_pkg::SBS_BP_ONE : sbs_pkg::SBS_BP_LONG));
	endproperty
	a_report: assert property (p_report) else $error("wrong report beep"); // [RULE7]

	property p_timeout;
		@(posedge CLK) disable iff (RST)
			(state == S_TOGGLE && win_out && !press) |=> state == S_IDLE && $stable(FB_SOUND);
	endproperty
	a_timeout: assert property (p_timeout) else $error("window expiry not handled"); // [RULE8]
endmodule

// ### hdl/sbs_pkg.sv
package sbs_pkg;
	// system clock rate
	localparam int unsigned CLK_HZ        = 250_000_000;
	// hold time that selects test run, in seconds
	localparam int unsigned HOLD_SEC      = 5;
	// window for the next step, in seconds
	localparam int unsigned WINDOW_SEC    = 20;
	// beep lengths, in milliseconds
	localparam int unsigned SHORT_MS      = 100;
	localparam int unsigned LONG_MS       = 600;
	localparam int unsigned GAP_MS        = 100;
	// derived cycle counts
	localparam longint unsigned HOLD_CYC  = longint'(HOLD_SEC) * CLK_HZ;
	localparam longint unsigned WIN_CYC   = longint'(WINDOW_SEC) * CLK_HZ;
	localparam longint unsigned SHORT_CYC = longint'(SHORT_MS) * (CLK_HZ / 1000);
	localparam longint unsigned LONG_CYC  = longint'(LONG_MS) * (CLK_HZ / 1000);
	localparam longint unsigned GAP_CYC   = longint'(GAP_MS) * (CLK_HZ / 1000);
	// feedback sound is on after reset
	localparam logic            FB_RESET  = 1'b1;
	// beep request kinds
	typedef enum logic [1:0] {
		SBS_BP_NONE   = 2'b00,
		SBS_BP_ONE    = 2'b01,
		SBS_BP_TWO    = 2'b10,
		SBS_BP_LONG   = 2'b11
	} sbs_beep_t;
endpackage

// ### hdl/sbs_beep_if.sv
// carries beep requests from the sequencer to the tone generator
interface sbs_beep_if;
	logic                 req;   // one-cycle request
	sbs_pkg::sbs_beep_t   kind;  // pattern to play
	logic                 tone;  // buzzer level
	modport seq (output req, output kind, input tone);
	modport gen (input req, input kind, output tone);
endinterface

// ### hdl/sbs_beeper.sv
module sbs_beeper #(
	parameter longint unsigned SHORT_CYC = sbs_pkg::SHORT_CYC,
	parameter longint unsigned LONG_CYC  = sbs_pkg::LONG_CYC,
	parameter longint unsigned GAP_CYC   = sbs_pkg::GAP_CYC
) (
	// clock and reset
	input wire logic    clk,
	input wire logic    rst,
	// request side
	sbs_beep_if.gen     bp
);
	logic [31:0] cnt;    // cycles left in current phase
	logic [1:0]  phase;  // remaining tone phases after the current one
	logic        gap;    // currently in silent gap

	// plays one short, two short, or one long tone; new request restarts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt     <= 32'h0000_0000;
			phase   <= 2'h0;
			gap     <= 1'b0;
			bp.tone <= 1'b0;
		end else if (bp.req) begin
			gap     <= 1'b0;
			bp.tone <= 1'b1;
			phase   <= (bp.kind == sbs_pkg::SBS_BP_TWO) ? 2'h1 : 2'h0;
			cnt     <= (bp.kind == sbs_pkg::SBS_BP_LONG) ? 32'(LONG_CYC) : 32'(SHORT_CYC);
		end else if (cnt > 32'h0000_0001) begin
			cnt <= cnt - 32'h0000_0001;
		end else if (bp.tone && phase != 2'h0) begin
			// end of first tone, insert a gap
			bp.tone <= 1'b0;
			gap     <= 1'b1;
			cnt     <= 32'(GAP_CYC);
		end else if (gap) begin
			// gap over, second tone
			gap     <= 1'b0;
			bp.tone <= 1'b1;
			phase   <= phase - 2'h1;
			cnt     <= 32'(SHORT_CYC);
		end else begin
			bp.tone <= 1'b0;
			cnt     <= 32'h0000_0000;
		end
	end
endmodule

// ### bench/sbs_btn_model.sv
// push button pressed by a technician
module sbs_btn_model (
	// clock
	input  wire logic CLK,
	// button level, high while pressed
	output logic      BTN
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released button is pulled low
	initial BTN = 1'b0;
	// press just after a falling edge, hold n cycles, release
	task automatic hold(input int n);
		@(negedge CLK);
		BTN = 1'b1;
		repeat (n) @(negedge CLK);
		BTN = 1'b0;
	endtask
endmodule

// ### bench/testbench.sv
// top bench for the service button sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// shortened counts for simulation
	localparam longint unsigned HC = 50;
	localparam longint unsigned WC = 200;
	localparam longint unsigned SC = 5;
	localparam longint unsigned LC = 20;
	localparam longint unsigned GC = 5;
	logic CLK = 1'b0;  // system clock
	logic RST = 1'b1;  // reset, active high
	wire logic BTN;    // button level
	logic AUTO_START;  // auto mode pulse
	logic TEST_RUN;    // test run pulse
	logic FB_SOUND;    // feedback sound setting
	logic BUZZER;      // buzzer level
	int fails = 0;     // mismatches
	int n_compared = 0;
	int n_auto, n_test, n_rise, last_len, run;
	logic exp_fb;      // expected feedback setting
	int k;
	int n;
	// clock toggles each half period
	always #2 CLK = ~CLK;
	sbs_btn_model u_btn (.CLK(CLK), .BTN(BTN));
	sbs_sequencer #(.HOLD_CYC(HC), .WIN_CYC(WC), .SHORT_CYC(SC), .LONG_CYC(LC), .GAP_CYC(GC)) dut_u (
		.CLK(CLK), .RST(RST), .BTN(BTN), .AUTO_START(AUTO_START), .TEST_RUN(TEST_RUN),
		.FB_SOUND(FB_SOUND), .BUZZER(BUZZER));
	// count pulses, beeps and the length of the last beep
	always @(posedge CLK) begin
		if (AUTO_START === 1'b1) n_auto <= n_auto + 1;
		if (TEST_RUN === 1'b1) n_test <= n_test + 1;
		if (BUZZER === 1'b1 && run == 0) n_rise <= n_rise + 1;
		if (BUZZER === 1'b1) run <= run + 1;
		else if (run != 0) begin
			last_len <= run;
			run <= 0;
		end
	end
	// expected beep length for a new setting
	function automatic int beep_len(input logic fb);
		return (fb === 1'b1) ? int'(SC) : int'(LC);
	endfunction
	// clear the monitor counters between steps
	task automatic clr();
		n_auto = 0;
		n_test = 0;
		n_rise = 0;
		last_len = 0;
		run = 0;
	endtask
	// one comparison
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	// wait a number of falling edges
	task automatic idle(input longint unsigned c);
		repeat (c) @(negedge CLK);
	endtask
	// print counts and verdict, then stop
	task automatic report_and_stop();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h80977EA3));
		clr();
		idle(5);
		RST = 1'b0;
		idle(1);
		chk(FB_SOUND === sbs_pkg::FB_RESET && BUZZER === 1'b0, "reset state");
		// short presses of random length: auto mode only
		for (k = 0; k < 3; k++) begin
			clr();
			u_btn.hold($urandom_range(4, 30));
			idle(20);
			chk(n_auto == 1 && n_test == 0 && n_rise == 0, "short press");
		end
		// long hold enters test run with one short beep
		clr();
		u_btn.hold(int'(HC) + 10);
		idle(10);
		chk(n_auto == 1 && n_test == 1, "test run entry");
		chk(n_rise == 1 && last_len >= int'(SC) && last_len <= int'(SC) + 1, "test run beep");
		// second long hold within the window gives two beeps
		idle($urandom_range(5, 120));
		clr();
		u_btn.hold(int'(HC) + 10);
		idle(30);
		chk(n_rise == 2 && FB_SOUND === sbs_pkg::FB_RESET, "toggle stage armed");
		// random number of toggles at random gaps
		exp_fb = sbs_pkg::FB_RESET;
		n = $urandom_range(3, 5);
		for (k = 0; k < n; k++) begin
			idle($urandom_range(0, 150));
			clr();
			u_btn.hold(5);
			idle(30);
			exp_fb = ~exp_fb;
			chk(FB_SOUND === exp_fb, "setting toggle");
			chk(n_rise == 1 && last_len >= beep_len(exp_fb) && last_len <= beep_len(exp_fb) + 1, "report beep");
		end
		// window runs out: next press is a plain auto start
		idle(WC + 20);
		clr();
		u_btn.hold(5);
		idle(30);
		chk(FB_SOUND === exp_fb && n_auto == 1 && n_rise == 0, "window expiry");
		// too short a second hold waits again, window counted from its release
		clr();
		u_btn.hold(int'(HC) + 10);
		idle(20);
		clr();
		u_btn.hold(30);
		chk(n_auto == 0 && n_test == 0 && n_rise == 0, "short second hold");
		idle(170);
		clr();
		u_btn.hold(int'(HC) + 10);
		idle(30);
		chk(n_auto == 0 && n_test == 0 && n_rise == 2, "window after short hold");
		// toggle stage runs out, then the wait for a second hold runs out
		idle(WC + 20);
		clr();
		u_btn.hold(int'(HC) + 10);
		idle(WC + 20);
		clr();
		u_btn.hold(5);
		idle(30);
		chk(FB_SOUND === exp_fb && n_auto == 1 && n_test == 0 && n_rise == 0, "second window expiry");
		// reset in mid-run brings back the power-on state
		RST = 1'b1;
		idle(2);
		chk(FB_SOUND === sbs_pkg::FB_RESET && BUZZER === 1'b0 && AUTO_START === 1'b0, "mid-run reset");
		RST = 1'b0;
		clr();
		u_btn.hold(5);
		idle(20);
		chk(n_auto == 1 && n_test == 0 && n_rise == 0, "press after reset");
		report_and_stop();
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
